// File: shared/dai_pkg.sv
// package: shared constants and types of the dac audio input link
package dai_pkg;
	// pcm formats, hardware pin codes
	localparam logic [1:0] FMT_LJ      = 2'h0;
	localparam logic [1:0] FMT_I2S     = 2'h1;
	localparam logic [1:0] FMT_RJ16    = 2'h2;
	localparam logic [1:0] FMT_RJ24    = 2'h3;
	// software format field codes
	localparam logic [3:0] SWF_OLM1    = 4'h8;
	localparam logic [3:0] SWF_OLM2    = 4'h9;
	localparam logic [3:0] SWF_OLM3    = 4'hA;
	localparam logic [3:0] SWF_OLM4    = 4'hB;
	localparam logic [3:0] SWF_TDM     = 4'hC;
	// upper mode pin codes
	localparam logic [2:0] UM_SSM      = 3'h0;
	localparam logic [2:0] UM_SSM_DEM  = 3'h1;
	localparam logic [2:0] UM_DSM      = 3'h2;
	localparam logic [2:0] UM_QSM      = 3'h3;
	localparam logic [2:0] UM_AUTO     = 3'h4;
	localparam logic [2:0] UM_AUTO_DEM = 3'h5;
	// speed modes
	typedef enum logic [1:0] {
		SPD_SINGLE = 2'h0,
		SPD_DOUBLE = 2'h1,
		SPD_QUAD   = 2'h2,
		SPD_AUTO   = 2'h3
	} dai_speed_type;
	// oversampling ratios per speed
	localparam logic [7:0] OSR_SINGLE  = 8'h80;
	localparam logic [7:0] OSR_DOUBLE  = 8'h40;
	localparam logic [7:0] OSR_QUAD    = 8'h20;
	// de-emphasis select
	localparam logic [1:0] DEM_OFF     = 2'h0;
	localparam logic [1:0] DEM_44K1    = 2'h2;
	// bit clocks per frame, slot and word widths in bits
	localparam int         BCK_128     = 128;
	localparam int         BCK_256     = 256;
	localparam int         SLOT_BITS   = 32;
	localparam int         W20         = 20;
	localparam int         W24         = 24;
	// one-line slot width in 128 fs mode
	localparam int         OLM1_SLOT   = 16;
	// auto-speed thresholds, master clocks per frame
	localparam logic [11:0] AUTO_DSM_MAX = 12'h200;
	localparam logic [11:0] AUTO_QSM_MAX = 12'h100;
	// link clock divider, 250 MHz / 32 = 7.8125 MHz bit clock
	localparam int         BCK_HALF    = 16;
endpackage

// File: shared/dai_if.sv
// interface: serial audio link between source and dac input
`timescale 1ns/100ps
interface dai_if;
	logic bitClock;
	logic frameClock;
	logic masterClock;
	logic serialDataIn1;
	logic serialDataIn4;
	modport dac (input bitClock, input frameClock, input masterClock, input serialDataIn1, input serialDataIn4);
	modport src (output bitClock, output frameClock, output masterClock, output serialDataIn1, output serialDataIn4);
endinterface

// File: hdl/dai_fifo.sv
// fifo: flip-flop buffer with valid and ready on both sides
`timescale 1ns/100ps
module dai_fifo #(
	parameter int WIDTH = 24,
	parameter int DEPTH = 8
) (
	// clock and reset
	input  wire logic             clk,
	input  wire logic             rstn,
	// fill side
	input  wire logic             inValid,
	output logic                  inReady,
	input  wire logic [WIDTH-1:0] inData,
	// drain side
	output logic                  outValid,
	input  wire logic             outReady,
	output logic      [WIDTH-1:0] outData
);
	localparam int AW = $clog2(DEPTH);
	if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_depth_check
		$error("fifo depth must be a power of two");
	end
	logic [WIDTH-1:0] mem_q [DEPTH];
	logic [AW:0]      wr_q;
	logic [AW:0]      rd_q;
	logic             push;
	logic             pop;
	assign inReady  = (wr_q - rd_q) != (AW+1)'(DEPTH);
	assign outValid = wr_q != rd_q;
	assign push     = inValid & inReady;
	assign pop      = outValid & outReady;
	assign outData  = mem_q[rd_q[AW-1:0]];
	always_ff @(posedge clk) begin
		if (!rstn) begin
			wr_q <= '0;
			rd_q <= '0;
		end else begin
			if (push) wr_q <= wr_q + 1'b1;
			if (pop) rd_q <= rd_q + 1'b1;
		end
	end
	always_ff @(posedge clk) begin
		if (push) mem_q[wr_q[AW-1:0]] <= inData;
	end
endmodule // dai_fifo

// File: hdl/dai_dac_end.sv
// device end: mode decode and serial audio receiver
`timescale 1ns/100ps
module dai_dac_end #(
	parameter int DEPTH = 8
) (
	// clock and reset
	input  wire logic        clk,
	input  wire logic        rstn,
	// serial link
	dai_if.dac               link,
	// mode pins
	input  wire logic        modePin0,
	input  wire logic        modePin1,
	input  wire logic        modePin2,
	input  wire logic        modePin3,
	input  wire logic        modePin4,
	// software fields
	input  wire logic        softwareMode,
	input  wire logic [3:0]  formatField,
	input  wire logic [1:0]  speedModeField,
	input  wire logic [1:0]  deemphField,
	input  wire logic        filterRolloffSelect,
	input  wire logic        bitstreamPcmSelect,
	input  wire logic [2:0]  bitstreamRateRatio,
	input  wire logic        bitstreamDirectPath,
	input  wire logic        bitstreamPhaseModEnable,
	input  wire logic        bitstreamPhaseModClockSel,
	input  wire logic        bitstreamStaticCheck,
	input  wire logic        bitstreamInvalidCheck,
	input  wire logic        autoMuteEnable,
	// decoded configuration
	output logic [3:0]       activeFormat,
	output logic [1:0]       activeSpeed,
	output logic [7:0]       oversampleRatio,
	output logic [1:0]       deemphSelect,
	output logic             slowRolloff,
	output logic             bitstreamMode,
	output logic [2:0]       bitstreamRate,
	output logic             directPath,
	output logic             phaseModOn,
	output logic             phaseModClk128,
	output logic [11:0]      masterPerFrame,
	// samples
	output logic             sampleValid,
	input  wire logic        sampleReady,
	output logic [26:0]      sampleData,
	output logic             bitstreamBad,
	output logic             muteControlOut
);
	if (DEPTH < 2) begin : g_depth_check
		$error("depth too small");
	end
	// pin and link synchronisers
	logic [6:0] s1_q;
	logic [6:0] s2_q;
	logic [6:0] s3_q;
	always_ff @(posedge clk) begin
		s1_q <= {link.masterClock, link.bitClock, link.frameClock, link.serialDataIn1, link.serialDataIn4, 2'b00};
		s2_q <= s1_q;
		s3_q <= s2_q;
	end
	logic [4:0] m1_q;
	logic [4:0] m2_q;
	always_ff @(posedge clk) begin
		m1_q <= {modePin4, modePin3, modePin2, modePin1, modePin0};
		m2_q <= m1_q;
	end
	logic bckRise;
	logic mckRise;
	logic frm;
	logic din1;
	logic din4;
	assign bckRise = s2_q[5] & ~s3_q[5];
	assign mckRise = s2_q[6] & ~s3_q[6];
	assign frm     = s2_q[4];
	assign din1    = s2_q[3];
	assign din4    = s2_q[2];
	// master clocks per frame
	logic [11:0] mcnt_q;
	logic        frmEdge;
	assign frmEdge = frm & ~s3_q[4];
	always_ff @(posedge clk) begin
		if (!rstn) begin
			mcnt_q         <= '0;
			masterPerFrame <= '0;
		end else if (frmEdge) begin
			masterPerFrame <= mcnt_q;
			mcnt_q         <= '0;
		end else if (mckRise) begin
			mcnt_q <= mcnt_q + 12'h001;
		end
	end
	// configuration decode
	logic [3:0] fmt_d;
	logic [1:0] spd_d;
	logic [1:0] dem_d;
	logic       bs_d;
	logic [2:0] rate_d;
	always_comb begin
		fmt_d  = {2'b00, m2_q[1:0]};
		spd_d  = dai_pkg::SPD_SINGLE;
		dem_d  = dai_pkg::DEM_OFF;
		bs_d   = 1'b0;
		rate_d = m2_q[2:0];
		unique case (m2_q[4:2])
			dai_pkg::UM_SSM: spd_d = dai_pkg::SPD_SINGLE;
			dai_pkg::UM_SSM_DEM: begin
				dem_d = dai_pkg::DEM_44K1;
			end
			dai_pkg::UM_DSM: spd_d = dai_pkg::SPD_DOUBLE;
			dai_pkg::UM_QSM: spd_d = dai_pkg::SPD_QUAD;
			dai_pkg::UM_AUTO: spd_d = dai_pkg::SPD_AUTO;
			dai_pkg::UM_AUTO_DEM: begin
				spd_d = dai_pkg::SPD_AUTO;
				dem_d = dai_pkg::DEM_44K1;
			end
			default: bs_d = 1'b1;
		endcase
		if (softwareMode) begin
			fmt_d  = formatField;
			spd_d  = speedModeField;
			dem_d  = deemphField;
			bs_d   = bitstreamPcmSelect;
			rate_d = bitstreamRateRatio;
		end
	end
	// auto speed from counted ratio
	logic [1:0] spdEff;
	always_comb begin
		spdEff = spd_d;
		if (spd_d == dai_pkg::SPD_AUTO) begin
			if (masterPerFrame <= dai_pkg::AUTO_QSM_MAX) spdEff = dai_pkg::SPD_QUAD;
			else if (masterPerFrame <= dai_pkg::AUTO_DSM_MAX) spdEff = dai_pkg::SPD_DOUBLE;
			else spdEff = dai_pkg::SPD_SINGLE;
		end
	end
	always_ff @(posedge clk) begin
		if (!rstn) begin
			activeFormat    <= '0;
			activeSpeed     <= dai_pkg::SPD_SINGLE;
			oversampleRatio <= dai_pkg::OSR_SINGLE;
			deemphSelect    <= dai_pkg::DEM_OFF;
			slowRolloff     <= 1'b0;
			bitstreamMode   <= 1'b0;
			bitstreamRate   <= '0;
			directPath      <= 1'b0;
			phaseModOn      <= 1'b0;
			phaseModClk128  <= 1'b0;
		end else begin
			activeFormat    <= fmt_d;
			activeSpeed     <= spdEff;
			oversampleRatio <= spdEff == dai_pkg::SPD_QUAD ? dai_pkg::OSR_QUAD :
				spdEff == dai_pkg::SPD_DOUBLE ? dai_pkg::OSR_DOUBLE : dai_pkg::OSR_SINGLE;
			deemphSelect    <= dem_d;
			slowRolloff     <= softwareMode & filterRolloffSelect;
			bitstreamMode   <= bs_d;
			bitstreamRate   <= rate_d;
			directPath      <= softwareMode & bitstreamDirectPath;
			phaseModOn      <= softwareMode & bitstreamPhaseModEnable;
			phaseModClk128  <= softwareMode & bitstreamPhaseModClockSel;
		end
	end
	// serial receiver: slot bit counter from frame edge
	logic [8:0]  bit_q;
	logic [23:0] sh1_q;
	logic [23:0] sh4_q;
	logic        lastFrm_q;
	logic        frameStart;
	logic        slotEnd;
	logic [5:0]  slotLen;
	logic [4:0]  wordLen;
	logic [2:0]  slot;
	logic        use4;
	logic        pm_q;
	logic        bad_q;
	assign frameStart = bckRise & (frm != lastFrm_q) & (fmt_d == dai_pkg::SWF_TDM ? frm : 1'b1);
	always_comb begin
		slotLen = 6'(dai_pkg::SLOT_BITS);
		wordLen = 5'(dai_pkg::W24);
		use4    = 1'b0;
		unique case (activeFormat)
			dai_pkg::SWF_OLM1: begin
				slotLen = 6'(dai_pkg::OLM1_SLOT);
				wordLen = 5'(dai_pkg::W20);
				use4    = 1'b1;
			end
			dai_pkg::SWF_OLM2: use4 = 1'b1;
			dai_pkg::SWF_OLM3: wordLen = 5'(dai_pkg::W20);
			default: wordLen = activeFormat == {2'b00, dai_pkg::FMT_RJ16} ? 5'h10 : 5'(dai_pkg::W24);
		endcase
	end
	assign slot    = 3'(bit_q / 9'(slotLen));
	assign slotEnd = bckRise & ((bit_q % 9'(slotLen)) == 9'(slotLen - 6'h01));
	always_ff @(posedge clk) begin
		if (!rstn) begin
			bit_q     <= '0;
			lastFrm_q <= 1'b0;
			sh1_q     <= '0;
			sh4_q     <= '0;
			pm_q      <= 1'b0;
			bad_q     <= 1'b0;
		end else if (bckRise) begin
			lastFrm_q <= frm;
			bit_q     <= frameStart ? 9'h000 : bit_q + 9'h001;
			if (frameStart || (bit_q % 9'(slotLen)) < 9'(wordLen)) begin
				sh1_q <= {sh1_q[22:0], din1};
				sh4_q <= {sh4_q[22:0], din4};
			end
			pm_q  <= din1;
			bad_q <= bitstreamMode & phaseModOn & (pm_q == din1) & bit_q[0] &
				(bitstreamStaticCheck | bitstreamInvalidCheck);
		end
	end
	// frame samples into fifo
	logic        fifoInValid;
	logic [26:0] fifoInData;
	assign fifoInValid = slotEnd & ~bitstreamMode & (slot < 3'h6 || !use4 || bit_q < 9'h0C0);
	assign fifoInData  = {slot, (use4 && slot >= 3'h6) ? sh4_q : sh1_q};
	dai_fifo #(.WIDTH(27), .DEPTH(DEPTH)) buffer (
		.clk      (clk),
		.rstn     (rstn),
		.inValid  (fifoInValid),
		.inReady  (),
		.inData   (fifoInData),
		.outValid (sampleValid),
		.outReady (sampleReady),
		.outData  (sampleData)
	);
	always_ff @(posedge clk) begin
		if (!rstn) begin
			bitstreamBad   <= 1'b0;
			muteControlOut <= 1'b0;
		end else begin
			bitstreamBad   <= bad_q;
			muteControlOut <= autoMuteEnable & bad_q;
		end
	end
endmodule // dai_dac_end

// File: hdl/dai_src_end.sv
// source end: makes link clocks and shifts tdm frames out
`timescale 1ns/100ps
module dai_src_end #(
	parameter int DEPTH = 8
) (
	// clock and reset
	input  wire logic        clk,
	input  wire logic        rstn,
	// serial link
	dai_if.src               link,
	// user samples, 32-bit slot left justified
	input  wire logic        wordValid,
	output logic             wordReady,
	input  wire logic [23:0] wordData
);
	logic        bufValid;
	logic        bufReady;
	logic [23:0] bufData;
	dai_fifo #(.WIDTH(24), .DEPTH(DEPTH)) buffer (
		.clk      (clk),
		.rstn     (rstn),
		.inValid  (wordValid),
		.inReady  (wordReady),
		.inData   (wordData),
		.outValid (bufValid),
		.outReady (bufReady),
		.outData  (bufData)
	);
	// bit clock divider, master clock at twice bit rate
	logic [4:0]  div_q;
	logic        bck_q;
	logic        mck_q;
	logic        fall;
	assign fall = (div_q == 5'(dai_pkg::BCK_HALF - 1)) & bck_q;
	always_ff @(posedge clk) begin
		if (!rstn) begin
			div_q <= '0;
			bck_q <= 1'b0;
			mck_q <= 1'b0;
		end else begin
			div_q <= div_q == 5'(dai_pkg::BCK_HALF - 1) ? 5'h00 : div_q + 5'h01;
			if (div_q == 5'(dai_pkg::BCK_HALF - 1)) bck_q <= ~bck_q;
			if (div_q[2:0] == 3'h7) mck_q <= ~mck_q;
		end
	end
	// tdm shifter: data changes on falling edge, frame pulse one bit wide
	logic [7:0]  pos_q;
	logic [31:0] sh_q;
	logic        frm_q;
	assign bufReady = fall & (pos_q[4:0] == 5'h1F);
	always_ff @(posedge clk) begin
		if (!rstn) begin
			pos_q <= 8'hFF;
			sh_q  <= '0;
			frm_q <= 1'b0;
		end else if (fall) begin
			pos_q <= pos_q + 8'h01;
			frm_q <= pos_q == 8'hFE;
			if (pos_q[4:0] == 5'h1F) sh_q <= bufValid ? {bufData, 8'h00} : 32'h0000_0000;
			else sh_q <= {sh_q[30:0], 1'b0};
		end
	end
	assign link.bitClock      = bck_q;
	assign link.masterClock   = mck_q;
	assign link.frameClock    = frm_q;
	assign link.serialDataIn1 = sh_q[31];
	assign link.serialDataIn4 = 1'b0;
endmodule // dai_src_end

// File: sim/dai_link_asserts.sv
// checker: link timing between source and dac ends
`timescale 1ns/100ps
module dai_link_asserts (
	// clock and reset
	input wire logic clk,
	input wire logic rstn,
	// link lines
	input wire logic bitClock,
	input wire logic frameClock,
	input wire logic masterClock,
	input wire logic serialDataIn1,
	input wire logic serialDataIn4
);
	localparam int BckLast = 15;
	localparam int MckLast = 7;
	localparam int FrmLast = 8191;
	logic [4:0]  bckRun_q;
	logic [3:0]  mckRun_q;
	logic [5:0]  frmHigh_q;
	logic [13:0] frmRun_q;
	logic [7:0]  bitIdx_q;
	logic        bckPrev_q, mckPrev_q, frmPrev_q, bckSeen_q, mckSeen_q, frmSeen_q;
	// bit clock level length
	always_ff @(posedge clk) begin
		bckPrev_q <= bitClock;
		bckRun_q  <= (!rstn || bitClock != bckPrev_q) ? 5'h0 : bckRun_q + 5'h1;
		bckSeen_q <= rstn && (bckSeen_q || bitClock != bckPrev_q);
	end
	// master clock level length
	always_ff @(posedge clk) begin
		mckPrev_q <= masterClock;
		mckRun_q  <= (!rstn || masterClock != mckPrev_q) ? 4'h0 : mckRun_q + 4'h1;
		mckSeen_q <= rstn && (mckSeen_q || masterClock != mckPrev_q);
	end
	// frame clock high time and period
	always_ff @(posedge clk) begin
		frmPrev_q <= frameClock;
		frmHigh_q <= (rstn && frameClock) ? frmHigh_q + 6'h1 : 6'h0;
		frmRun_q  <= (!rstn || (frameClock && !frmPrev_q)) ? 14'h0 : frmRun_q + 14'h1;
	end
	// bit position within frame
	always_ff @(posedge clk) begin
		if (!rstn) begin
			bitIdx_q  <= 8'h0;
			frmSeen_q <= 1'b0;
		end else if (bitClock && !bckPrev_q) begin
			bitIdx_q  <= frameClock ? 8'h0 : bitIdx_q + 8'h1;
			frmSeen_q <= frmSeen_q || frameClock;
		end
	end
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rstn);
	sequence s_bck_rise;
		bitClock && !bckPrev_q;
	endsequence
	sequence s_frm_mark;
		bitClock && !bckPrev_q && frameClock && frmSeen_q;
	endsequence
	a_bck_half: assert property (bckSeen_q && bitClock != bckPrev_q |-> bckRun_q == BckLast)
		else $error("bit clock half period wrong");
	a_mck_half: assert property (mckSeen_q && masterClock != mckPrev_q |-> mckRun_q == MckLast)
		else $error("master clock half period wrong");
	a_data_held: assert property (bitClock && $past(bitClock) |-> $stable(serialDataIn1) && $stable(serialDataIn4))
		else $error("data moved while bit clock high");
	a_frame_edge_low: assert property ($changed(frameClock) |-> !bitClock)
		else $error("frame clock moved while bit clock high");
	a_frame_one_bit: assert property ($fell(frameClock) |-> frmHigh_q == 6'h20)
		else $error("frame clock not high one bit");
	a_frame_bits: assert property (s_frm_mark |-> bitIdx_q == 8'hFF)
		else $error("frame not 256 bits");
	a_frame_period: assert property (frmSeen_q && $rose(frameClock) |-> frmRun_q == FrmLast)
		else $error("frame period wrong");
	a_slot_pad: assert property (s_bck_rise |-> !frmSeen_q || bitIdx_q[4:0] < 5'h18 || !serialDataIn1)
		else $error("slot padding not zero");
endmodule // dai_link_asserts

// File: sim/tb_dac_audio_input_mode_decode.sv
// testbench: mode decode and tdm transfer across both link ends
`timescale 1ns/100ps
module tb_dac_audio_input_mode_decode;
	logic        clk = 1'b0;
	logic        rstn = 1'b0;
	logic [4:0]  modePins = 5'h00;
	logic [3:0]  formatField = 4'h0;
	logic [1:0]  speedModeField = 2'h0, deemphField = 2'h0;
	logic [2:0]  bitstreamRateRatio = 3'h0;
	logic        softwareMode = 1'b0, filterRolloffSelect = 1'b0, bitstreamPcmSelect = 1'b0;
	logic        bitstreamDirectPath = 1'b0, bitstreamPhaseModEnable = 1'b0, bitstreamPhaseModClockSel = 1'b0;
	logic        bitstreamStaticCheck = 1'b0, bitstreamInvalidCheck = 1'b0, autoMuteEnable = 1'b0;
	logic        sampleReady = 1'b1, wordValid = 1'b0;
	logic [23:0] wordData = 24'h000000;
	logic [3:0]  activeFormat;
	logic [1:0]  activeSpeed, deemphSelect;
	logic [7:0]  oversampleRatio;
	logic [2:0]  bitstreamRate, prevSlot, up;
	logic [11:0] masterPerFrame;
	logic [26:0] sampleData;
	logic        slowRolloff, bitstreamMode, directPath, phaseModOn, phaseModClk128;
	logic        sampleValid, bitstreamBad, muteControlOut, wordReady, slotKnown, refused;
	logic [23:0] expQ[$];
	int          errCount = 0, numChecks = 0, i, k;
	dai_if linkIf();
	dai_src_end #(.DEPTH(8)) dai_src_end_inst (.clk, .rstn, .link(linkIf.src), .wordValid, .wordReady, .wordData);
	dai_dac_end #(.DEPTH(8)) dai_dac_end_inst (
		.clk, .rstn, .link(linkIf.dac), .modePin0(modePins[0]), .modePin1(modePins[1]), .modePin2(modePins[2]),
		.modePin3(modePins[3]), .modePin4(modePins[4]), .softwareMode, .formatField, .speedModeField, .deemphField,
		.filterRolloffSelect, .bitstreamPcmSelect, .bitstreamRateRatio, .bitstreamDirectPath, .bitstreamPhaseModEnable,
		.bitstreamPhaseModClockSel, .bitstreamStaticCheck, .bitstreamInvalidCheck, .autoMuteEnable, .activeFormat,
		.activeSpeed, .oversampleRatio, .deemphSelect, .slowRolloff, .bitstreamMode, .bitstreamRate, .directPath,
		.phaseModOn, .phaseModClk128, .masterPerFrame, .sampleValid, .sampleReady, .sampleData, .bitstreamBad,
		.muteControlOut);
	dai_link_asserts dai_link_asserts_inst (.clk, .rstn, .bitClock(linkIf.bitClock), .frameClock(linkIf.frameClock),
		.masterClock(linkIf.masterClock), .serialDataIn1(linkIf.serialDataIn1), .serialDataIn4(linkIf.serialDataIn4));
	always #2 clk = ~clk;
	// random drain stalls
	always @(posedge clk) sampleReady <= (4'($urandom) != 4'h0);
	function automatic logic [1:0] spd_of(input logic [2:0] u);
		if (u == dai_pkg::UM_DSM) return dai_pkg::SPD_DOUBLE;
		if (u == dai_pkg::UM_QSM) return dai_pkg::SPD_QUAD;
		return dai_pkg::SPD_SINGLE;
	endfunction
	function automatic logic [7:0] osr_of(input logic [1:0] s);
		if (s == dai_pkg::SPD_QUAD) return dai_pkg::OSR_QUAD;
		return (s == dai_pkg::SPD_DOUBLE) ? dai_pkg::OSR_DOUBLE : dai_pkg::OSR_SINGLE;
	endfunction
	function automatic logic [1:0] dem_of(input logic [2:0] u);
		return (u == dai_pkg::UM_SSM_DEM || u == dai_pkg::UM_AUTO_DEM) ? dai_pkg::DEM_44K1 : dai_pkg::DEM_OFF;
	endfunction
	// master clocks per frame made by the source end
	localparam int MpfExp = dai_pkg::BCK_256 * 2 * dai_pkg::BCK_HALF / 16;
	function automatic logic [1:0] auto_of(input int mpf);
		if (mpf <= int'(dai_pkg::AUTO_QSM_MAX)) return dai_pkg::SPD_QUAD;
		return (mpf <= int'(dai_pkg::AUTO_DSM_MAX)) ? dai_pkg::SPD_DOUBLE : dai_pkg::SPD_SINGLE;
	endfunction
	task automatic closeOut;
		$display("checks %0d errors %0d", numChecks, errCount);
		if (errCount == 0 && numChecks > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask
	task automatic check_val(input string what, input logic [26:0] exp, input logic [26:0] got);
		numChecks++;
		if (got !== exp) begin
			errCount++;
			$display("BAD %s expected %0h seen %0h", what, exp, got);
		end
	endtask
	task automatic settle;
		repeat (4) @(posedge clk);
		@(negedge clk);
	endtask
	task automatic push_word(input logic [23:0] w);
		int n;
		wordValid <= 1'b1;
		wordData <= w;
		expQ.push_back(w);
		for (n = 0; n < 4000; n++) begin
			@(negedge clk);
			if (wordReady === 1'b1) break;
			refused = 1'b1;
		end
		if (n == 4000) begin
			errCount++;
			closeOut();
		end
		@(posedge clk);
	endtask
	task automatic drain;
		int n;
		for (n = 0; n < 30000 && expQ.size() != 0; n++) @(posedge clk);
		if (expQ.size() != 0) begin
			errCount++;
			closeOut();
		end
	endtask
	// received samples against pushed words
	always @(negedge clk) begin
		if (rstn && sampleValid === 1'b1 && sampleReady && sampleData[23:0] !== 24'h0) begin
			if (expQ.size() == 0) begin
				check_val("spare", 27'h0, sampleData);
			end else begin
				check_val("word", 27'(expQ.pop_front()), 27'(sampleData[23:0]));
				if (slotKnown) check_val("slot", 27'(3'(prevSlot + 3'h1)), 27'(sampleData[26:24]));
				prevSlot = sampleData[26:24];
				slotKnown = 1'b1;
			end
		end
	end
	initial begin
		void'($urandom(46));
		repeat (5) @(posedge clk);
		rstn <= 1'b1;
		filterRolloffSelect <= 1'b1;
		// every pin code, no reset between
		for (i = 0; i < 32; i++) begin
			@(posedge clk);
			modePins <= 5'(i);
			settle();
			up = modePins[4:2];
			check_val("slow", 27'h0, 27'(slowRolloff));
			check_val("bsmode", 27'(up[2] && up[1]), 27'(bitstreamMode));
			if (up[2] && up[1]) begin
				check_val("bsrate", 27'(modePins[2:0]), 27'(bitstreamRate));
			end else begin
				check_val("format", 27'(modePins[1:0]), 27'(activeFormat));
				check_val("dem", 27'(dem_of(up)), 27'(deemphSelect));
				if (!up[2]) begin
					check_val("speed", 27'(spd_of(up)), 27'(activeSpeed));
					check_val("osr", 27'(osr_of(spd_of(up))), 27'(oversampleRatio));
				end else begin
					// no frame counted yet this early
					check_val("auto", 27'(auto_of(0)), 27'(activeSpeed));
				end
			end
		end
		// software fields against random pins
		for (i = 0; i < 24; i++) begin
			@(posedge clk);
			k = $urandom_range(0, 8);
			softwareMode <= 1'b1;
			formatField <= (k < 4) ? 4'(k) : 4'(k + 4);
			speedModeField <= 2'($urandom_range(0, 2));
			{deemphField, filterRolloffSelect, bitstreamPcmSelect, bitstreamRateRatio, bitstreamDirectPath,
				bitstreamPhaseModEnable, bitstreamPhaseModClockSel, bitstreamStaticCheck, bitstreamInvalidCheck,
				autoMuteEnable} <= 13'($urandom);
			modePins <= 5'($urandom);
			settle();
			// let a bit clock rise pass so the bitstream check sees the new setup
			repeat (4 * dai_pkg::BCK_HALF) @(posedge clk);
			@(negedge clk);
			check_val("format", 27'(formatField), 27'(activeFormat));
			check_val("speed", 27'(speedModeField), 27'(activeSpeed));
			check_val("osr", 27'(osr_of(speedModeField)), 27'(oversampleRatio));
			check_val("dem", 27'(deemphField), 27'(deemphSelect));
			check_val("slow", 27'(filterRolloffSelect), 27'(slowRolloff));
			check_val("bsmode", 27'(bitstreamPcmSelect), 27'(bitstreamMode));
			check_val("bsrate", 27'(bitstreamRateRatio), 27'(bitstreamRate));
			check_val("direct", 27'(bitstreamDirectPath), 27'(directPath));
			check_val("pm", 27'(bitstreamPhaseModEnable), 27'(phaseModOn));
			check_val("pmclk", 27'(bitstreamPhaseModClockSel), 27'(phaseModClk128));
			if (!autoMuteEnable) check_val("mute", 27'h0, 27'(muteControlOut));
			if (!(bitstreamPcmSelect && bitstreamPhaseModEnable && (bitstreamStaticCheck || bitstreamInvalidCheck)))
				check_val("bad", 27'h0, 27'(bitstreamBad));
		end
		// tdm bursts overfilling the source buffer, single, double and quad speed
		for (i = 0; i < 3; i++) begin
			@(posedge clk);
			formatField <= dai_pkg::SWF_TDM;
			speedModeField <= 2'(i);
			bitstreamPcmSelect <= 1'b0;
			slotKnown = 1'b0;
			refused = 1'b0;
			repeat (dai_pkg::BCK_256 * 2 * dai_pkg::BCK_HALF) @(posedge clk);
			repeat (12) push_word(24'($urandom_range(1, 24'hFFFFFF)));
			wordValid <= 1'b0;
			drain();
			@(negedge clk);
			check_val("full", 27'h1, 27'(refused));
			check_val("mpf", 27'(MpfExp), 27'(masterPerFrame));
		end
		// automatic speed from the counted ratio
		@(posedge clk);
		speedModeField <= dai_pkg::SPD_AUTO;
		settle();
		check_val("auto", 27'(auto_of(MpfExp)), 27'(activeSpeed));
		check_val("osr", 27'(osr_of(auto_of(MpfExp))), 27'(oversampleRatio));
		closeOut();
	end
endmodule // tb_dac_audio_input_mode_decode
